//--- sef_core.sv
// serial port error flags, clearing sequences, shared interrupt and halt wake-up
//
// Implementation choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - master with low select is a mode fault
// - mode fault sets flag, may interrupt
// - mode fault clears port output enable
// - mode fault clears master select
// - mode fault cleared by status read, control write
// - enable and master locked while fault set
// - byte done with flag set means overrun
// - overrun keeps first byte, drops later ones
// - status read clears overrun flag
// - data write during transfer collides, ignored
// - write collision never interrupts
// - data write in sequence keeps collision
// - receive buffer read synchronously, no collision
// - unwritten slave echoes last byte taken into receive buffer
// - in wait, works and interrupts wake
// - in halt, no mode fault; interface idle unless select low at entry
// - in slave halt only completion wakes
// - several bytes in halt set overrun
// - halt wake needs select low at entry
// - completion, mode fault and overrun share one masked vector
// - completion cleared by status then data access
module sef_core
    import sef_pkg::*;
(
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [sef_pkg::SEF_ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [sef_pkg::SEF_BUS_W-1:0] wb_dat_i,
    output logic      [sef_pkg::SEF_BUS_W-1:0] wb_dat_o,
    output logic                               wb_ack_o,
    input  wire logic                          sck_i,
    input  wire logic                          mosi_i,
    input  wire logic                          ss_n_i,
    output logic                               miso_o,
    output logic                               miso_oe_o,
    input  wire logic                          global_mask_i,
    input  wire logic                          halt_i,
    output logic                               irq_o,
    output logic                               wake_halt_o,
    output logic                               port_en_o,
    output logic                               master_o
);
    import sef_pkg::*;

    function automatic logic hit(input logic [SEF_ADR_W-1:0] adr, input logic [SEF_ADR_W-1:0] off);
        hit = adr == off;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic [2:0]            pins;
    logic                  sck_s;
    logic                  mosi_s;
    logic                  ss_n_s;
    logic                  busy;
    logic                  done;
    logic [SEF_BYTE_W-1:0] rx_byte;
    logic                  sh_miso;
    logic                  sh_en;
    logic                  ss_eff;

    sef_sync #(.WIDTH(3)) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({sck_i, mosi_i, ss_n_i}),
        .sync_o  (pins)
    );
    assign sck_s  = pins[2];
    assign mosi_s = pins[1];
    assign ss_n_s = pins[0];

    sef_ctrl_s             ctrl_reg,  ctrl_next;
    sef_flags_s            flags_reg, flags_next;
    sef_sel_s              sel_reg,   sel_next;
    sef_halt_e             hst_reg,   hst_next;
    logic [SEF_BYTE_W-1:0] rx_buf_reg, rx_buf_next;
    logic [SEF_BYTE_W-1:0] tx_hold_reg, tx_hold_next;
    logic                  mode_fault_flag_seq_reg, mode_fault_flag_seq_next;
    logic                  transfer_complete_flag_seq_reg, transfer_complete_flag_seq_next;
    logic                  write_collision_flag_seq_reg, write_collision_flag_seq_next;
    logic                  ack_next;
    logic [SEF_BUS_W-1:0]  dat_next;
    logic                  irq_next;
    logic                  wake_next;
    logic                  oe_next;

    // receive shifter runs in slave role only; blocked while halted unselected
    assign sh_en = ctrl_reg.port_output_enable && !ctrl_reg.master_select && !ss_eff
                   && (hst_reg != SEF_H_BLOCKED);

    sef_shift u_shift (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .en_i   (sh_en),
        .sck_i  (sck_s),
        .mosi_i (mosi_s),
        .cpol_i (ctrl_reg.clock_polarity),
        .cpha_i (ctrl_reg.clock_phase),
        .load_i (tx_hold_reg),
        .busy_o (busy),
        .done_o (done),
        .rx_o   (rx_byte),
        .miso_o (sh_miso)
    );

    ////////////////////////////////////////////////////////////////////////////
    logic access;
    logic wr;
    logic rd;
    logic cr_wr;
    logic csr_touch;
    logic csr_read;
    logic dr_wr;
    logic dr_rd;
    logic mode_fault_flag_set;
    logic transfer_complete_flag_clr;
    logic accept;
    logic ovr_set;
    logic write_collision_flag_set;
    logic tx_ok;

    assign ss_eff    = sel_reg.software_select_management ? sel_reg.software_select_level : ss_n_s;
    assign access    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr        = access && wb_we_i && wb_sel_i[0];
    assign rd        = access && !wb_we_i;
    assign cr_wr     = wr && hit(wb_adr_i, SEF_OFF_CTRL);
    assign csr_touch = access && hit(wb_adr_i, SEF_OFF_STATUS);
    assign csr_read  = rd && hit(wb_adr_i, SEF_OFF_STATUS);
    assign dr_wr     = wr && hit(wb_adr_i, SEF_OFF_DATA);
    assign dr_rd     = rd && hit(wb_adr_i, SEF_OFF_DATA);

    assign mode_fault_flag_set = ctrl_reg.master_select && !ss_eff && !halt_i && (hst_reg == SEF_H_RUN);
    assign transfer_complete_flag_clr = transfer_complete_flag_seq_reg && (dr_rd || dr_wr);
    assign accept   = done && (!flags_reg.transfer_complete_flag || transfer_complete_flag_clr);
    assign ovr_set  = done && flags_reg.transfer_complete_flag && !transfer_complete_flag_clr;
    assign write_collision_flag_set = dr_wr && busy;
    assign tx_ok    = dr_wr && !busy && !(flags_reg.transfer_complete_flag && !transfer_complete_flag_seq_reg);

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        ctrl_next     = ctrl_reg;
        sel_next      = sel_reg;
        mode_fault_flag_seq_next = mode_fault_flag_seq_reg;
        if (cr_wr) begin
            ctrl_next     = sef_ctrl_s'(wb_dat_i[SEF_BYTE_W-1:0]);
            mode_fault_flag_seq_next = 1'b0;
            if (flags_reg.mode_fault_flag && !mode_fault_flag_seq_reg) begin
                ctrl_next.port_output_enable = 1'b0;
                ctrl_next.master_select      = 1'b0;
            end
        end
        if (csr_read && flags_reg.mode_fault_flag) begin
            mode_fault_flag_seq_next = 1'b1;
        end
        if (wr && hit(wb_adr_i, SEF_OFF_STATUS)) begin
            sel_next = sef_sel_s'(wb_dat_i[2:0]);
        end
        if (mode_fault_flag_set) begin
            ctrl_next.port_output_enable = 1'b0;
            ctrl_next.master_select      = 1'b0;
        end
    end

    always_comb begin
        flags_next    = flags_reg;
        transfer_complete_flag_seq_next = transfer_complete_flag_seq_reg;
        write_collision_flag_seq_next = write_collision_flag_seq_reg;
        rx_buf_next   = rx_buf_reg;
        tx_hold_next  = tx_hold_reg;
        flags_next.mode_fault_flag = mode_fault_flag_set
            || (flags_reg.mode_fault_flag && !(mode_fault_flag_seq_reg && cr_wr));
        flags_next.transfer_complete_flag = done
            || (flags_reg.transfer_complete_flag && !transfer_complete_flag_clr);
        flags_next.overrun_flag = ovr_set || (flags_reg.overrun_flag && !csr_read);
        flags_next.write_collision_flag = write_collision_flag_set
            || (flags_reg.write_collision_flag && !(write_collision_flag_seq_reg && dr_rd));
        if (csr_touch && flags_reg.transfer_complete_flag) begin
            transfer_complete_flag_seq_next = 1'b1;
        end else if (transfer_complete_flag_clr) begin
            transfer_complete_flag_seq_next = 1'b0;
        end
        if (csr_read && flags_reg.write_collision_flag) begin
            write_collision_flag_seq_next = 1'b1;
        end else if (dr_rd) begin
            write_collision_flag_seq_next = 1'b0;
        end
        if (accept) begin
            rx_buf_next  = rx_byte;
            tx_hold_next = rx_byte;
        end
        if (tx_ok) begin
            tx_hold_next = wb_dat_i[SEF_BYTE_W-1:0];
        end
    end

    // select level caught at halt entry
    always_comb begin
        hst_next = hst_reg;
        unique case (hst_reg)
            SEF_H_RUN: begin
                if (halt_i) begin
                    hst_next = (!ss_eff && !ctrl_reg.master_select) ? SEF_H_ARMED : SEF_H_BLOCKED;
                end
            end
            SEF_H_ARMED, SEF_H_BLOCKED: begin
                if (!halt_i) begin
                    hst_next = SEF_H_RUN;
                end
            end
            default: hst_next = SEF_H_RUN;
        endcase
    end

    always_comb begin
        ack_next = access;
        dat_next = '0;
        if (rd) begin
            if (hit(wb_adr_i, SEF_OFF_CTRL)) begin
                dat_next = {SEF_PAD_ZERO, ctrl_reg};
            end else if (hit(wb_adr_i, SEF_OFF_STATUS)) begin
                dat_next = {SEF_PAD_ZERO, flags_reg, 1'b0, sel_reg};
            end else if (hit(wb_adr_i, SEF_OFF_DATA)) begin
                dat_next = {SEF_PAD_ZERO, rx_buf_reg};
            end
        end
        irq_next  = ctrl_reg.peripheral_interrupt_enable && !global_mask_i
                    && (flags_reg.transfer_complete_flag || flags_reg.mode_fault_flag
                        || flags_reg.overrun_flag);
        wake_next = (hst_reg == SEF_H_ARMED) && ctrl_reg.peripheral_interrupt_enable
                    && !global_mask_i && flags_reg.transfer_complete_flag;
        oe_next   = sh_en && !sel_reg.slave_output_disable;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg     <= SEF_CTRL_RST;
            flags_reg    <= SEF_FLAGS_RST;
            sel_reg      <= SEF_SEL_RST;
            hst_reg      <= SEF_H_RUN;
            rx_buf_reg   <= SEF_BYTE_ZERO;
            tx_hold_reg  <= SEF_BYTE_ZERO;
            mode_fault_flag_seq_reg <= 1'b0;
            transfer_complete_flag_seq_reg <= 1'b0;
            write_collision_flag_seq_reg <= 1'b0;
            wb_ack_o     <= 1'b0;
            wb_dat_o     <= '0;
            irq_o        <= 1'b0;
            wake_halt_o  <= 1'b0;
            miso_oe_o    <= 1'b0;
            miso_o       <= 1'b0;
        end else begin
            ctrl_reg     <= ctrl_next;
            flags_reg    <= flags_next;
            sel_reg      <= sel_next;
            hst_reg      <= hst_next;
            rx_buf_reg   <= rx_buf_next;
            tx_hold_reg  <= tx_hold_next;
            mode_fault_flag_seq_reg <= mode_fault_flag_seq_next;
            transfer_complete_flag_seq_reg <= transfer_complete_flag_seq_next;
            write_collision_flag_seq_reg <= write_collision_flag_seq_next;
            wb_ack_o     <= ack_next;
            wb_dat_o     <= dat_next;
            irq_o        <= irq_next;
            wake_halt_o  <= wake_next;
            miso_oe_o    <= oe_next;
            miso_o       <= sh_miso;
        end
    end

    // register copies, so both outputs stand straight on flip-flops
    logic port_en_reg;
    logic master_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_en_reg <= 1'b0;
            master_reg  <= 1'b0;
        end else begin
            port_en_reg <= ctrl_next.port_output_enable;
            master_reg  <= ctrl_next.master_select;
        end
    end
    assign port_en_o = port_en_reg;
    assign master_o  = master_reg;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_fault_drops_role: assert property (mode_fault_flag_set |=> flags_reg.mode_fault_flag
        && !ctrl_reg.port_output_enable && !ctrl_reg.master_select)
        else $error("mode fault did not drop enable and master");
    chk_fault_outputs: assert property (mode_fault_flag_set |=> !port_en_o && !master_o)
        else $error("fault left output enable or master set");
    chk_fault_clear: assert property ($fell(flags_reg.mode_fault_flag) |->
        $past(mode_fault_flag_seq_reg && cr_wr))
        else $error("mode fault cleared outside its sequence");
    chk_fault_lock: assert property (flags_reg.mode_fault_flag && !mode_fault_flag_seq_reg && cr_wr
        |=> !ctrl_reg.port_output_enable && !ctrl_reg.master_select)
        else $error("enable or master set while fault pending");
    chk_overrun_set: assert property (ovr_set |=> flags_reg.overrun_flag && $stable(rx_buf_reg))
        else $error("overrun lost or buffer overwritten");
    chk_overrun_clear: assert property (csr_read && !ovr_set |=> !flags_reg.overrun_flag)
        else $error("status read did not clear overrun");
    chk_collision_set: assert property (dr_wr && busy |=> flags_reg.write_collision_flag
        && (tx_hold_reg == $past(accept ? rx_byte : tx_hold_reg)))
        else $error("busy write not refused");
    chk_collision_keep: assert property (flags_reg.write_collision_flag && !dr_rd
        |=> flags_reg.write_collision_flag)
        else $error("collision flag dropped without data read");
    chk_collision_clear: assert property ($fell(flags_reg.write_collision_flag) |->
        $past(write_collision_flag_seq_reg && dr_rd))
        else $error("collision flag cleared out of sequence");
    chk_vector_shared: assert property (irq_o == $past(ctrl_reg.peripheral_interrupt_enable && !global_mask_i
        && (flags_reg.transfer_complete_flag || flags_reg.mode_fault_flag || flags_reg.overrun_flag)))
        else $error("interrupt output wrong");
    chk_vector_cause: assert property (!(flags_reg.transfer_complete_flag || flags_reg.mode_fault_flag
        || flags_reg.overrun_flag) |=> !irq_o)
        else $error("interrupt without an event flag");
    chk_halt_wake: assert property (wake_halt_o |-> $past(hst_reg == SEF_H_ARMED
        && flags_reg.transfer_complete_flag))
        else $error("halt wake without completion in slave halt");
    chk_done_clear: assert property ($fell(flags_reg.transfer_complete_flag) |->
        $past(transfer_complete_flag_seq_reg && (dr_rd || dr_wr)))
        else $error("completion cleared out of sequence");
    chk_ack_one: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held for two cycles");

    cov_fault_seq: cover property (flags_reg.mode_fault_flag ##[1:40] !flags_reg.mode_fault_flag);
    cov_overrun:   cover property (ovr_set);
    cov_collision: cover property (write_collision_flag_set ##[1:40] !flags_reg.write_collision_flag);
    cov_halt_wake: cover property (wake_halt_o);
endmodule
`default_nettype wire

//--- sef_pkg.sv
// shared constants and types of the serial port error flag and wake-up block
package sef_pkg;
    // register byte offsets on the bus
    localparam logic [3:0] SEF_OFF_CTRL   = 4'h0;
    localparam logic [3:0] SEF_OFF_STATUS = 4'h4;
    localparam logic [3:0] SEF_OFF_DATA   = 4'h8;
    localparam int         SEF_ADR_W      = 4;
    localparam int         SEF_BUS_W      = 32;
    localparam int         SEF_BYTE_W     = 8;
    localparam int         SEF_CNT_W      = 3;
    localparam logic [2:0] SEF_LAST_BIT   = 3'h7;
    localparam logic [2:0] SEF_FIRST_BIT  = 3'h0;
    localparam logic [7:0] SEF_BYTE_ZERO  = 8'h00;
    localparam logic [23:0] SEF_PAD_ZERO  = 24'h000000;

    // control register, bit 7 down to bit 0
    typedef struct packed {
        logic       peripheral_interrupt_enable;
        logic       port_output_enable;
        logic       divide_by_two_disable;
        logic       master_select;
        logic       clock_polarity;
        logic       clock_phase;
        logic [1:0] clock_rate_select;
    } sef_ctrl_s;

    // hardware flags, status bits 7 down to 4
    typedef struct packed {
        logic transfer_complete_flag;
        logic write_collision_flag;
        logic overrun_flag;
        logic mode_fault_flag;
    } sef_flags_s;

    // software bits of the status register, bits 2 down to 0
    typedef struct packed {
        logic slave_output_disable;
        logic software_select_management;
        logic software_select_level;
    } sef_sel_s;

    localparam sef_ctrl_s  SEF_CTRL_RST  = '0;
    localparam sef_flags_s SEF_FLAGS_RST = '0;
    localparam sef_sel_s   SEF_SEL_RST   = '0;

    // halt tracking, gray along run -> armed only; run -> blocked flips both bits
    typedef enum logic [1:0] {
        SEF_H_RUN     = 2'h0,
        SEF_H_ARMED   = 2'h1,
        SEF_H_BLOCKED = 2'h3
    } sef_halt_e;
endpackage

//--- sef_sync.sv
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sef_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // pins idle high after reset so a released select does not look active
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '1;
            sync_reg <= '1;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule
`default_nettype wire

//--- sef_shift.sv
// slave byte shifter clocked by sampled edges of the serial clock pin
`timescale 1ns/1ps
`default_nettype none
module sef_shift
    import sef_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  en_i,
    input  wire logic                  sck_i,
    input  wire logic                  mosi_i,
    input  wire logic                  cpol_i,
    input  wire logic                  cpha_i,
    input  wire logic [SEF_BYTE_W-1:0] load_i,
    output logic                       busy_o,
    output logic                       done_o,
    output logic      [SEF_BYTE_W-1:0] rx_o,
    output logic                       miso_o
);
    logic                  sck_d_reg;
    logic [SEF_CNT_W-1:0]  cnt_reg;
    logic [SEF_CNT_W-1:0]  cnt_next;
    logic [SEF_BYTE_W-1:0] sh_reg;
    logic [SEF_BYTE_W-1:0] sh_next;
    logic                  done_reg;
    logic                  done_next;
    logic [SEF_BYTE_W-1:0] rx_reg;
    logic [SEF_BYTE_W-1:0] rx_next;
    logic                  sample;

    // capture edge: leading edge for phase 0, trailing edge for phase 1
    assign sample = en_i && (sck_i != sck_d_reg) && ((sck_i ^ cpol_i) != cpha_i);

    always_comb begin
        cnt_next  = cnt_reg;
        sh_next   = sh_reg;
        done_next = 1'b0;
        rx_next   = rx_reg;
        if (!en_i) begin
            cnt_next = SEF_FIRST_BIT;
            sh_next  = load_i;
        end else if (sample) begin
            sh_next  = {sh_reg[SEF_BYTE_W-2:0], mosi_i};
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == SEF_LAST_BIT) begin
                done_next = 1'b1;
                rx_next   = {sh_reg[SEF_BYTE_W-2:0], mosi_i};
            end
        end else if (cnt_reg == SEF_FIRST_BIT) begin
            // between bytes the next byte to send tracks the hold register
            sh_next = load_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sck_d_reg <= 1'b0;
            cnt_reg   <= SEF_FIRST_BIT;
            sh_reg    <= SEF_BYTE_ZERO;
            done_reg  <= 1'b0;
            rx_reg    <= SEF_BYTE_ZERO;
        end else begin
            sck_d_reg <= sck_i;
            cnt_reg   <= cnt_next;
            sh_reg    <= sh_next;
            done_reg  <= done_next;
            rx_reg    <= rx_next;
        end
    end

    assign busy_o = cnt_reg != SEF_FIRST_BIT;
    assign done_o = done_reg;
    assign rx_o   = rx_reg;
    assign miso_o = sh_reg[SEF_BYTE_W-1];
endmodule
`default_nettype wire

//--- sef_master_model.sv
// remote serial master model driving the slave pins
`timescale 1ns/1ps
`default_nettype none
module sef_master_model (
    output logic      sck_o,
    output logic      mosi_o,
    output logic      ss_n_o,
    input  wire logic miso_i
);
    initial begin
        sck_o  = 1'b0;
        mosi_o = 1'b0;
        ss_n_o = 1'b1;
    end
    ////////////////////////////////////////////////////////////////
    // select driven by this master alone
    task automatic sel(input logic lvl);
        ss_n_o = lvl;
        #400;
    endtask
    // msb first, mode 0; miso taken at the capture edge, before the slave shifts
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi_o = tx[i];
            #400 rx[i] = miso_i;
            sck_o = 1'b1;
            #400 sck_o = 1'b0;
        end
        // released line toggles rather than holding the last bit
        #400 mosi_o = ~mosi_o;
    endtask
endmodule
`default_nettype wire

//--- sef_core_test.sv
// self-checking bench for the serial port error flag block
`timescale 1ns/1ps
`default_nettype none
module sef_core_test;
    import sef_pkg::*;
    logic        clk_i, rst_i, cyc, stb, wen, mask, halt;
    logic [3:0]  adr;
    logic [31:0] dat, rdat;
    logic        ack, sck, mosi, ss_n, miso, miso_oe, irq, wake, pen, mst;
    logic [7:0]  q, q2, r;
    logic [3:0]  sel, lane;
    logic [7:0]  rxq[$];
    int          err_count, compares, cycles;
    sef_core sef_core_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wen),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .sck_i(sck),
        .mosi_i(mosi), .ss_n_i(ss_n), .miso_o(miso), .miso_oe_o(miso_oe), .global_mask_i(mask),
        .halt_i(halt), .irq_o(irq), .wake_halt_o(wake), .port_en_o(pen), .master_o(mst));
    sef_master_model sef_master_model_inst (.sck_o(sck), .mosi_o(mosi), .ss_n_o(ss_n),
        .miso_i(miso_oe ? miso : ~mosi));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_count++;
            give_verdict();
        end
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // classic cycle held until ack is sampled high
    task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d, output logic [7:0] o);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        wen <= we;
        sel <= lane;
        adr <= a;
        dat <= {24'h000000, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        o = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rdc(input string n, input logic [3:0] a, input logic [7:0] e);
        logic [7:0] v;
        wb(1'b0, a, 8'h00, v);
        chk(n, e, v);
    endtask
    task automatic send(input logic [7:0] b, output logic [7:0] e);
        sef_master_model_inst.sel(1'b0);
        sef_master_model_inst.xfer(b, e);
        sef_master_model_inst.sel(1'b1);
        repeat (4) @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {cyc, stb, wen, mask, halt, rst_i} = 6'h01;
        adr = 4'h0;
        sel = 4'hf;
        lane = 4'hf;
        dat = 32'h00000000;
        {err_count, compares, cycles} = 0;
        void'($urandom(32'h18d9));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b1, 4'h0, 8'hc0, q);
        rdc("unmapped", 4'hc, 8'h00);
        // low lane off: write acked but ignored
        lane = 4'he;
        wb(1'b1, 4'h0, 8'h00, q);
        lane = 4'hf;
        rdc("ignored", 4'h0, 8'hc0);
        r = 8'($urandom);
        rxq.push_back(r);
        send(r, q);
        chk("irq", 8'h01, {7'h0, irq});
        mask <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("masked", 8'h00, {7'h0, irq});
        mask <= 1'b0;
        send(8'($urandom), q);
        chk("echo", rxq[0], q);
        rdc("status", 4'h4, 8'ha0);
        rdc("data", 4'h8, rxq.pop_front());
        rdc("status", 4'h4, 8'h00);
        $display("overrun test done");
        r = 8'($urandom);
        fork
            send(r, q);
            begin
                repeat (30) @(posedge clk_i);
                wb(1'b1, 4'h8, ~r, q2);
            end
        join
        rdc("status", 4'h4, 8'hc0);
        wb(1'b1, 4'h8, ~r, q);
        rdc("status", 4'h4, 8'h40);
        chk("irq", 8'h00, {7'h0, irq});
        rdc("data", 4'h8, r);
        rdc("status", 4'h4, 8'h00);
        $display("collision test done");
        wb(1'b1, 4'h0, 8'hd0, q);
        chk("master", 8'h01, {7'h0, mst});
        sef_master_model_inst.sel(1'b0);
        repeat (6) @(posedge clk_i);
        chk("enable", 8'h00, {7'h0, pen});
        chk("master", 8'h00, {7'h0, mst});
        chk("irq", 8'h01, {7'h0, irq});
        wb(1'b1, 4'h0, 8'hd0, q);
        chk("enable", 8'h00, {7'h0, pen});
        rdc("status", 4'h4, 8'h10);
        sef_master_model_inst.sel(1'b1);
        wb(1'b1, 4'h0, 8'hd0, q);
        chk("master", 8'h01, {7'h0, mst});
        rdc("status", 4'h4, 8'h00);
        wb(1'b1, 4'h0, 8'hc0, q);
        $display("mode fault test done");
        halt <= 1'b1;
        send(8'($urandom), q);
        chk("wake", 8'h00, {7'h0, wake});
        halt <= 1'b0;
        rdc("status", 4'h4, 8'h00);
        sef_master_model_inst.sel(1'b0);
        halt <= 1'b1;
        r = 8'($urandom);
        sef_master_model_inst.xfer(r, q);
        sef_master_model_inst.xfer(8'($urandom), q);
        repeat (4) @(posedge clk_i);
        chk("wake", 8'h01, {7'h0, wake});
        sef_master_model_inst.sel(1'b1);
        halt <= 1'b0;
        rdc("status", 4'h4, 8'ha0);
        rdc("data", 4'h8, r);
        send(8'($urandom), q); // extra transfer after wake
        chk("echo", r, q);
        $display("halt test done");
        give_verdict();
    end
endmodule
`default_nettype wire
